// ==== hdl/usart_irq_status_flags.sv ====
// interrupt mask and channel status word of the serial channel
//
// Overview of operation
// - ones written to set port set mask
// - ones written to clear port clear mask
// - zero bits leave mask bits unchanged
// - manchester mask at bits 20 and 24
// - mask gates interrupts, resets zero, read-only
// - manchester error sticky until status reset
// - bits 23..20 show modem input levels
// - modem change flags latch, cleared on read
// - nack flag sticky until nack reset
// - bit 12 follows dma buffer full
// - bit 10 underrun in spi slave, else iterations
// - bit 10 latches on its selected event
// - tx empty needs both empty and enabled
// - timeout latches, zero when disabled, cleared
// - parity flag, multidrop latches on parity one
// - framing flag latches on low stop bit
// - overrun flag latches on overrun
// - break flag latches on break start/end
// - tx ready rules incl. break and enable
// - characters while disabled show on re-enable
// - rx ready sets on char, clears on read
// - error flags sticky until status reset
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module usart_irq_status_flags #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  output logic                   IRQ,
  input  wire logic              RX_CHAR_DONE,
  input  wire logic              RHR_READ,
  input  wire logic              RX_ENABLED,
  input  wire logic              TX_ENABLED,
  input  wire logic              HOLD_EMPTY,
  input  wire logic              SHIFT_EMPTY,
  input  wire logic              PARITY_ERR_EVT,
  input  wire logic              PARITY_BIT_ONE_EVT,
  input  wire logic              MULTIDROP_MODE,
  input  wire logic              FRAME_ERR_EVT,
  input  wire logic              OVERRUN_EVT,
  input  wire logic              BREAK_START_EVT,
  input  wire logic              BREAK_END_EVT,
  input  wire logic              REPETITION_LIMIT_FLAG_LIMIT_EVT,
  input  wire logic              SPI_UNDERRUN_EVT,
  input  wire logic              SPI_SLAVE_MODE,
  input  wire logic              NACK_EVT,
  input  wire logic              MANCH_ERR_EVT,
  input  wire logic              TIMEOUT_EVT,
  input  wire logic              TIMEOUT_VALUE_ZERO,
  input  wire logic              DMA_BUF_FULL,
  input  wire logic              CTS_IN,
  input  wire logic              DCD_IN,
  input  wire logic              DSR_IN,
  input  wire logic              RI_IN,
  input  wire logic              STATUS_RESET_CMD,
  input  wire logic              NACK_RESET_CMD,
  input  wire logic              START_BREAK_CMD,
  input  wire logic              STOP_BREAK_CMD,
  input  wire logic              START_TIMEOUT_CMD,
  input  wire logic              REARM_TIMEOUT_CMD
);

  // ==========================================================================
  // parameter check
  initial begin
    if (ADDR_W < 5 || ADDR_W > 8) begin
      $error("ADDR_W must lie between 5 and 8");
    end
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0] mask;
    logic        manch;
    logic        nack;
    logic        repetition_limit_flag;
    logic        parity_err_flag;
    logic        frame;
    logic        overrun_err_flag;
    logic        brk;
    logic        tout;
    logic        receive_ready;
    logic        transmit_ready;
    logic        transmitter_empty;
    logic        brk_hold;
    logic        dma_full;
    logic [3:0]  img;
    logic [3:0]  chg;
    logic [31:0] rdata;
    logic        irq;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic [7:0]  addr8;
  logic        wr_set;
  logic        wr_clr;
  logic        rd_mask;
  logic        rd_status;
  logic [31:0] wr_bits;
  logic [31:0] mask_view;
  logic [31:0] status_word;
  logic [31:0] status_nxt_word;
  logic [31:0] irq_gate;
  logic [31:0] irq_gate_nxt;
  logic [3:0]  modem_in;

  assign addr8     = 8'(ADDR);
  assign wr_set    = WR && (addr8 == status_pkg::OFF_IRQ_SET);
  assign wr_clr    = WR && (addr8 == status_pkg::OFF_IRQ_CLEAR);
  assign rd_mask   = RD && (addr8 == status_pkg::OFF_IRQ_MASK);
  assign rd_status = RD && (addr8 == status_pkg::OFF_STATUS);
  assign modem_in  = {CTS_IN, DCD_IN, DSR_IN, RI_IN};

  // alias position folds onto the one stored manchester bit
  always_comb begin
    wr_bits = WDATA & status_pkg::MASK_VALID;
    wr_bits[status_pkg::BIT_MANCH_MASK] = WDATA[status_pkg::BIT_MANCH_MASK]
                                        | WDATA[status_pkg::BIT_MANCH_ALIAS];
  end

  // mask read view: both positions report the same bit
  always_comb begin
    mask_view = s_r.mask;
    mask_view[status_pkg::BIT_MANCH_ALIAS] = s_r.mask[status_pkg::BIT_MANCH_MASK];
  end

  // status word assembly from a state copy; rx ready hidden while disabled
  function automatic logic [31:0] build_status(input state_type st, input logic rx_en);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[status_pkg::BIT_RECEIVE_READY]   = st.receive_ready & rx_en;
    w[status_pkg::BIT_TRANSMIT_READY]   = st.transmit_ready;
    w[status_pkg::BIT_BREAK]   = st.brk;
    w[status_pkg::BIT_OVERRUN] = st.overrun_err_flag;
    w[status_pkg::BIT_FRAME]   = st.frame;
    w[status_pkg::BIT_PARITY]  = st.parity_err_flag;
    w[status_pkg::BIT_TIMEOUT] = st.tout;
    w[status_pkg::BIT_TRANSMITTER_EMPTY] = st.transmitter_empty;
    w[status_pkg::BIT_REPETITION_LIMIT_FLAG]    = st.repetition_limit_flag;
    w[status_pkg::BIT_DMAFULL] = st.dma_full;
    w[status_pkg::BIT_NACK]    = st.nack;
    w[status_pkg::BIT_CHG_HI:status_pkg::BIT_CHG_LO] = st.chg;
    w[status_pkg::BIT_IMG_HI:status_pkg::BIT_IMG_LO] = st.img;
    w[status_pkg::BIT_MANCH]   = st.manch;
    return w;
  endfunction

  // gate for the interrupt: manchester status bit enabled by mask bit 20
  function automatic logic [31:0] build_gate(input logic [31:0] m);
    logic [31:0] g;
    g = m & status_pkg::IRQ_SOURCES;
    g[status_pkg::BIT_MANCH] = m[status_pkg::BIT_MANCH_MASK];
    g[status_pkg::BIT_IMG_HI:status_pkg::BIT_IMG_LO] = 4'h0;
    return g;
  endfunction

  assign status_word = build_status(s_r, RX_ENABLED);
  assign irq_gate    = build_gate(s_r.mask);

  // ==========================================================================
  // next state; every hardware set wins over a same-cycle clear, except that a zero time-out value keeps the time-out flag down
  always_comb begin
    s_nxt = s_r;

    // mask: set port then clear port, never both in one cycle
    if (wr_set) begin
      s_nxt.mask = s_r.mask | wr_bits;
    end else if (wr_clr) begin
      s_nxt.mask = s_r.mask & ~wr_bits;
    end

    // sticky error flags cleared by the status reset command
    if (STATUS_RESET_CMD) begin
      s_nxt.manch = 1'b0;
      s_nxt.repetition_limit_flag  = 1'b0;
      s_nxt.parity_err_flag  = 1'b0;
      s_nxt.frame = 1'b0;
      s_nxt.overrun_err_flag  = 1'b0;
      s_nxt.brk   = 1'b0;
    end
    if (MANCH_ERR_EVT) begin
      s_nxt.manch = 1'b1;
    end
    if (SPI_SLAVE_MODE ? SPI_UNDERRUN_EVT : REPETITION_LIMIT_FLAG_LIMIT_EVT) begin
      s_nxt.repetition_limit_flag = 1'b1;
    end
    if (MULTIDROP_MODE ? PARITY_BIT_ONE_EVT : PARITY_ERR_EVT) begin
      s_nxt.parity_err_flag = 1'b1;
    end
    if (FRAME_ERR_EVT) begin
      s_nxt.frame = 1'b1;
    end
    if (OVERRUN_EVT) begin
      s_nxt.overrun_err_flag = 1'b1;
    end
    if (BREAK_START_EVT || BREAK_END_EVT) begin
      s_nxt.brk = 1'b1;
    end

    // non-acknowledge has its own reset command
    if (NACK_RESET_CMD) begin
      s_nxt.nack = 1'b0;
    end
    if (NACK_EVT) begin
      s_nxt.nack = 1'b1;
    end

    // receive time-out; a zero time-out value keeps the flag down
    if (START_TIMEOUT_CMD || REARM_TIMEOUT_CMD) begin
      s_nxt.tout = 1'b0;
    end
    if (TIMEOUT_EVT) begin
      s_nxt.tout = 1'b1;
    end
    if (TIMEOUT_VALUE_ZERO) begin
      s_nxt.tout = 1'b0;
    end

    // receive ready keeps latching while disabled so it shows on re-enable
    if (RHR_READ) begin
      s_nxt.receive_ready = 1'b0;
    end
    if (RX_CHAR_DONE) begin
      s_nxt.receive_ready = 1'b1;
    end

    // break request blocks both transmit flags until stopped or disabled
    if (STOP_BREAK_CMD || !TX_ENABLED) begin
      s_nxt.brk_hold = 1'b0;
    end
    if (START_BREAK_CMD) begin
      s_nxt.brk_hold = 1'b1;
    end
    s_nxt.transmit_ready   = TX_ENABLED && HOLD_EMPTY && !s_nxt.brk_hold;
    s_nxt.transmitter_empty = TX_ENABLED && HOLD_EMPTY && SHIFT_EMPTY
                    && !s_nxt.brk_hold;

    // dma buffer-full is an image only, no latching
    s_nxt.dma_full = DMA_BUF_FULL;

    // modem images and change flags; read of status clears the flags
    s_nxt.img = modem_in;
    if (rd_status) begin
      s_nxt.chg = 4'h0;
    end
    s_nxt.chg = s_nxt.chg | (modem_in ^ s_r.img);

    // read data for the cycle after the strobe; unmapped reads zero
    if (rd_mask) begin
      s_nxt.rdata = mask_view;
    end else if (rd_status) begin
      s_nxt.rdata = status_word;
    end else if (RD) begin
      s_nxt.rdata = status_pkg::UNMAPPED_DATA;
    end

    // interrupt from the next state so it tracks flags without extra lag
    s_nxt.irq = |(status_nxt_word & irq_gate_nxt);
  end

  assign status_nxt_word = build_status(s_nxt, RX_ENABLED);
  assign irq_gate_nxt    = build_gate(s_nxt.mask);

  // ==========================================================================
  // state register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s_r          <= '0;
      s_r.mask     <= status_pkg::MASK_RESET;
      s_r.rdata    <= status_pkg::RDATA_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA = s_r.rdata;
  assign IRQ   = s_r.irq;

  // ==========================================================================
  // assertions
  default clocking dflt_cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_mask_set;
    wr_set |=> ((s_r.mask & $past(wr_bits)) == $past(wr_bits));
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("set port failed to set mask bits");

  property p_mask_clear;
    wr_clr |=> ((s_r.mask & $past(wr_bits)) == 32'h0000_0000);
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("clear port failed to clear mask bits");

  property p_mask_keep;
    (wr_set || wr_clr) |=> (((s_r.mask ^ $past(s_r.mask)) & ~$past(wr_bits)) == 32'h0000_0000);
  endproperty
  a_mask_keep: assert property (p_mask_keep)
    else $error("unwritten mask bit changed");

  property p_manch_alias;
    rd_mask |=> (RDATA[status_pkg::BIT_MANCH_ALIAS] == RDATA[status_pkg::BIT_MANCH_MASK])
                && (RDATA[status_pkg::BIT_MANCH_MASK] == $past(s_r.mask[status_pkg::BIT_MANCH_MASK]));
  endproperty
  a_manch_alias: assert property (p_manch_alias)
    else $error("manchester mask alias reads wrong");

  property p_irq_gate;
    ##1 (IRQ == $past(|(status_nxt_word & irq_gate_nxt)));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt output disagrees with status and mask");

  property p_manch_sticky;
    (MANCH_ERR_EVT || (s_r.manch && !STATUS_RESET_CMD)) |=> s_r.manch;
  endproperty
  a_manch_sticky: assert property (p_manch_sticky)
    else $error("manchester error flag lost");

  property p_modem_image;
    rd_status ##1 1'b1 |-> RDATA[status_pkg::BIT_IMG_HI:status_pkg::BIT_IMG_LO]
                           == $past(modem_in, 2);
  endproperty
  a_modem_image: assert property (p_modem_image)
    else $error("modem image does not match inputs");

  property p_modem_change;
    (modem_in != s_r.img) |=> ((s_r.chg & $past(modem_in ^ s_r.img)) == $past(modem_in ^ s_r.img));
  endproperty
  a_modem_change: assert property (p_modem_change)
    else $error("modem change not latched");

  property p_modem_read_clear;
    (rd_status && modem_in == s_r.img) |=> (s_r.chg == 4'h0);
  endproperty
  a_modem_read_clear: assert property (p_modem_read_clear)
    else $error("status read did not clear change flags");

  property p_nack_sticky;
    (NACK_EVT || (s_r.nack && !NACK_RESET_CMD)) |=> s_r.nack;
  endproperty
  a_nack_sticky: assert property (p_nack_sticky)
    else $error("nack flag lost");

  property p_dma_follow;
    ##1 (s_r.dma_full == $past(DMA_BUF_FULL));
  endproperty
  a_dma_follow: assert property (p_dma_follow)
    else $error("dma buffer-full image wrong");

  property p_repetition_limit_flag_select;
    (SPI_SLAVE_MODE ? SPI_UNDERRUN_EVT : REPETITION_LIMIT_FLAG_LIMIT_EVT) |=> s_r.repetition_limit_flag;
  endproperty
  a_repetition_limit_flag_select: assert property (p_repetition_limit_flag_select)
    else $error("bit 10 missed its selected event");

  property p_break_blocks_tx;
    START_BREAK_CMD |=> !s_r.transmit_ready && !s_r.transmitter_empty;
  endproperty
  a_break_blocks_tx: assert property (p_break_blocks_tx)
    else $error("transmit flags set after start-break");

  property p_transmitter_empty_cause;
    s_r.transmitter_empty |-> $past(TX_ENABLED && HOLD_EMPTY && SHIFT_EMPTY);
  endproperty
  a_transmitter_empty_cause: assert property (p_transmitter_empty_cause)
    else $error("tx empty set without both registers empty");

  property p_tx_enable_ready;
    (TX_ENABLED && HOLD_EMPTY && !START_BREAK_CMD && (STOP_BREAK_CMD || !s_r.brk_hold))
      |=> s_r.transmit_ready;
  endproperty
  a_tx_enable_ready: assert property (p_tx_enable_ready)
    else $error("tx ready not set with empty holding register");

  property p_timeout_zero;
    TIMEOUT_VALUE_ZERO |=> !s_r.tout;
  endproperty
  a_timeout_zero: assert property (p_timeout_zero)
    else $error("timeout flag set with zero time-out value");

  property p_timeout_clear;
    ((START_TIMEOUT_CMD || REARM_TIMEOUT_CMD) && !TIMEOUT_EVT) |=> !s_r.tout;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear)
    else $error("timeout flag not cleared by command");

  property p_parity_mode;
    (MULTIDROP_MODE && PARITY_BIT_ONE_EVT) or (!MULTIDROP_MODE && PARITY_ERR_EVT) |=> s_r.parity_err_flag;
  endproperty
  a_parity_mode: assert property (p_parity_mode)
    else $error("parity flag missed its event");

  property p_errors_latch;
    (FRAME_ERR_EVT |=> s_r.frame) and (OVERRUN_EVT |=> s_r.overrun_err_flag)
      and ((BREAK_START_EVT || BREAK_END_EVT) |=> s_r.brk);
  endproperty
  a_errors_latch: assert property (p_errors_latch)
    else $error("error flag missed its event");

  property p_errors_sticky;
    (!STATUS_RESET_CMD && (s_r.parity_err_flag || s_r.frame || s_r.overrun_err_flag || s_r.brk || s_r.repetition_limit_flag))
      |=> ($past(s_r.parity_err_flag) -> s_r.parity_err_flag) && ($past(s_r.frame) -> s_r.frame)
          && ($past(s_r.overrun_err_flag) -> s_r.overrun_err_flag) && ($past(s_r.brk) -> s_r.brk)
          && ($past(s_r.repetition_limit_flag) -> s_r.repetition_limit_flag);
  endproperty
  a_errors_sticky: assert property (p_errors_sticky)
    else $error("sticky error flag dropped without status reset");

  property p_receive_ready_cycle;
    (RX_CHAR_DONE |=> s_r.receive_ready) and ((RHR_READ && !RX_CHAR_DONE) |=> !s_r.receive_ready);
  endproperty
  a_receive_ready_cycle: assert property (p_receive_ready_cycle)
    else $error("rx ready set or clear wrong");

  property p_receive_ready_hidden;
    (rd_status && !RX_ENABLED) |=> !RDATA[status_pkg::BIT_RECEIVE_READY];
  endproperty
  a_receive_ready_hidden: assert property (p_receive_ready_hidden)
    else $error("rx ready visible while receiver disabled");

  c_irq_raise: cover property (wr_set ##[1:8] IRQ);
  c_modem_read: cover property (s_r.chg != 4'h0 ##1 rd_status ##1 s_r.chg == 4'h0);
  c_rx_reenable: cover property (!RX_ENABLED && RX_CHAR_DONE ##[1:8] RX_ENABLED && s_r.receive_ready);

endmodule

`default_nettype wire

// ==== shared/status_pkg.sv ====
// constants shared by the serial channel interrupt mask and status block
package status_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  OFF_IRQ_SET     = 8'h08;
  localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h10;
  localparam logic [7:0]  OFF_STATUS      = 8'h14;

  // ==========================================================================
  // reset values
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  // mask bits that exist; bit 24 is an alias of bit 20 and is not stored
  localparam logic [31:0] MASK_VALID      = 32'h001F_37E7;
  // status bits that can raise the interrupt (modem images excluded)
  localparam logic [31:0] IRQ_SOURCES     = 32'h010F_37E7;

  // ==========================================================================
  // field positions in the status word and mask
  localparam int BIT_RECEIVE_READY    = 0;
  localparam int BIT_TRANSMIT_READY    = 1;
  localparam int BIT_BREAK    = 2;
  localparam int BIT_OVERRUN  = 5;
  localparam int BIT_FRAME    = 6;
  localparam int BIT_PARITY   = 7;
  localparam int BIT_TIMEOUT  = 8;
  localparam int BIT_TRANSMITTER_EMPTY  = 9;
  localparam int BIT_REPETITION_LIMIT_FLAG     = 10;
  localparam int BIT_DMAFULL  = 12;
  localparam int BIT_NACK     = 13;
  localparam int BIT_CHG_LO   = 16;
  localparam int BIT_CHG_HI   = 19;
  localparam int BIT_IMG_LO   = 20;
  localparam int BIT_IMG_HI   = 23;
  localparam int BIT_MANCH    = 24;
  localparam int BIT_MANCH_MASK  = 20;
  localparam int BIT_MANCH_ALIAS = 24;

endpackage

// ==== sim/usart_irq_status_flags_tb.sv ====
// self-checking bench for the interrupt mask and channel status block
`timescale 1ns/1ps
`default_nettype none

module usart_irq_status_flags_tb;
  // ==========================================================================
  // stimulus and observation
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic [18:0] evt     = 19'h0_0000;
  logic [11:0] lvl     = 12'h000;
  int          fail_count  = 0;
  int          check_count = 0;

  // evt and lvl keep the many side inputs in two vectors so tasks can index them
  usart_irq_status_flags #(.ADDR_W(8)) uut (
    .CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .RX_CHAR_DONE(evt[0]), .RHR_READ(evt[1]),
    .RX_ENABLED(lvl[0]), .TX_ENABLED(lvl[1]), .HOLD_EMPTY(lvl[2]), .SHIFT_EMPTY(lvl[3]),
    .PARITY_ERR_EVT(evt[2]), .PARITY_BIT_ONE_EVT(evt[3]), .MULTIDROP_MODE(lvl[4]),
    .FRAME_ERR_EVT(evt[4]), .OVERRUN_EVT(evt[5]), .BREAK_START_EVT(evt[6]),
    .BREAK_END_EVT(evt[7]), .REPETITION_LIMIT_FLAG_LIMIT_EVT(evt[8]), .SPI_UNDERRUN_EVT(evt[9]),
    .SPI_SLAVE_MODE(lvl[5]), .NACK_EVT(evt[10]), .MANCH_ERR_EVT(evt[11]),
    .TIMEOUT_EVT(evt[12]), .TIMEOUT_VALUE_ZERO(lvl[6]), .DMA_BUF_FULL(lvl[7]),
    .CTS_IN(lvl[11]), .DCD_IN(lvl[10]), .DSR_IN(lvl[9]), .RI_IN(lvl[8]),
    .STATUS_RESET_CMD(evt[13]), .NACK_RESET_CMD(evt[14]), .START_BREAK_CMD(evt[15]),
    .STOP_BREAK_CMD(evt[16]), .START_TIMEOUT_CMD(evt[17]), .REARM_TIMEOUT_CMD(evt[18])
  );

  // ==========================================================================
  // clock, 40 ns period
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, released at the next edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  // read data launch at the edge that takes the strobe; judge them at the following
  // edge, before any update there, so inputs always move on the edge itself
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(posedge clk_sys);
    chk(rdata & m, e);
  endtask

  task automatic pulse(input int idx);
    @(posedge clk_sys);
    evt[idx] <= 1'b1;
    @(posedge clk_sys);
    evt[idx] <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(status_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("reset values done");
  endtask

  task automatic t_mask();
    wr_reg(status_pkg::OFF_IRQ_SET, 32'hFFFF_FFFF);
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h011F_37E7);
    wr_reg(status_pkg::OFF_IRQ_CLEAR, 32'h0100_0000);
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h000F_37E7);
    wr_reg(status_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h000F_37E4);
    wr_reg(status_pkg::OFF_IRQ_SET, 32'h0010_0001);
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h011F_37E5);
    // the mask view is read-only; a write there must be dropped
    wr_reg(status_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h011F_37E5);
    wr_reg(status_pkg::OFF_IRQ_CLEAR, 32'hFFFF_FFFF);
    rd_chk(status_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("mask ports done");
  endtask

  // each sticky flag: set, survive idle cycles, then cleared by status reset
  task automatic t_sticky();
    int ev[7] = '{2, 4, 5, 6, 7, 8, 11};
    int sb[7] = '{7, 6, 5, 2, 2, 10, 24};
    for (int i = 0; i < 7; i++) begin
      pulse(ev[i]);
      idle(3);
      rd_chk(status_pkg::OFF_STATUS, 32'h1 << sb[i], 32'h1 << sb[i]);
      pulse(13);
      rd_chk(status_pkg::OFF_STATUS, 32'h1 << sb[i], 32'h0);
    end
    lvl[4] <= 1'b1;
    pulse(3);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0080, 32'h0000_0080);
    lvl[4] <= 1'b0;
    lvl[5] <= 1'b1;
    pulse(13);
    pulse(8);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0400, 32'h0);
    pulse(9);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0400, 32'h0000_0400);
    lvl[5] <= 1'b0;
    pulse(13);
    $display("sticky flags done");
  endtask

  task automatic t_nack_irq();
    pulse(10);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_2000, 32'h0000_2000);
    chk({31'h0, irq}, 32'h0);
    wr_reg(status_pkg::OFF_IRQ_SET, 32'h0000_2000);
    idle(1);
    chk({31'h0, irq}, 32'h1);
    pulse(13);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_2000, 32'h0000_2000);
    pulse(14);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_2000, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr_reg(status_pkg::OFF_IRQ_CLEAR, 32'h0000_2000);
    $display("nack and irq done");
  endtask

  task automatic t_timeout_dma();
    pulse(12);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0100, 32'h0000_0100);
    pulse(17);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0100, 32'h0);
    pulse(12);
    pulse(18);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0100, 32'h0);
    lvl[6] <= 1'b1;
    pulse(12);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0100, 32'h0);
    lvl[6] <= 1'b0;
    lvl[7] <= 1'b1;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_1000, 32'h0000_1000);
    lvl[7] <= 1'b0;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_1000, 32'h0);
    $display("timeout and dma done");
  endtask

  task automatic t_modem();
    lvl[11:8] <= 4'h5;
    idle(3);
    rd_chk(status_pkg::OFF_STATUS, 32'h00FF_0000, 32'h0055_0000);
    rd_chk(status_pkg::OFF_STATUS, 32'h00FF_0000, 32'h0050_0000);
    lvl[11:8] <= 4'hC;
    idle(3);
    rd_chk(status_pkg::OFF_STATUS, 32'h00FF_0000, 32'h00C9_0000);
    $display("modem lines done");
  endtask

  task automatic t_tx_rx();
    lvl[3:1] <= 3'b101;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0202, 32'h0);
    lvl[2] <= 1'b1;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0202, 32'h0000_0202);
    lvl[3] <= 1'b0;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0202, 32'h0000_0002);
    lvl[3] <= 1'b1;
    pulse(15);
    idle(1);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0202, 32'h0);
    pulse(16);
    idle(1);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0202, 32'h0000_0202);
    lvl[1] <= 1'b0;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0202, 32'h0);
    pulse(0);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0001, 32'h0);
    lvl[0] <= 1'b1;
    idle(2);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
    pulse(1);
    rd_chk(status_pkg::OFF_STATUS, 32'h0000_0001, 32'h0);
    $display("transmit and receive done");
  endtask

  // ==========================================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_mask();
    t_sticky();
    t_nack_irq();
    t_timeout_dma();
    t_modem();
    t_tx_rx();
    results();
  end

  // the tests need well under 1000 cycles; 5000 means a hang
  initial begin
    #(40 * 5000);
    fail_count++;
    results();
  end
endmodule

`default_nettype wire
